/* File: rtl/tec_pkg.sv */
// Purpose: Constants shared by the timer/event counter.
// Assumes: One system clock at 250 MHz.
// Notes: Register selects are this block's own codes.
package tec_pkg;
  localparam int TEC_WIDTH_DEF = 16;
  localparam logic [1:0] TEC_SEL_LOW = 2'h0;
  localparam logic [1:0] TEC_SEL_HIGH = 2'h1;
  localparam logic [1:0] TEC_SEL_CTRL = 2'h2;
  localparam int TEC_MODE_HI = 7;
  localparam int TEC_MODE_LO = 6;
  localparam int TEC_RUN_BIT = 4;
  localparam int TEC_EDGE_BIT = 3;
  localparam int TEC_PSC_HI = 2;
  localparam int TEC_PSC_LO = 0;
  localparam logic [7:0] TEC_CTRL_RESET = 8'h00;
  localparam logic [7:0] TEC_CTRL_MASK = 8'hDF;
  localparam logic [1:0] TEC_DIV16_CYCLES = 2'h3;
  typedef enum logic [1:0] {
    TEC_OFF,
    TEC_EVENT,
    TEC_TIMER,
    TEC_PULSE
  } tec_mode_e;
endpackage

/* File: rtl/tec_counter.sv */
// Purpose: Count-up timer/event counter, 8 or 16 bit.
// Assumes: Registers are reached through a simple select/strobe port.
// Notes: Preload content is undefined until software writes it.
//
// Overview of operation
// - Up-counter, 8 or 16 bits wide.
// - Timer, event count and pulse width modes.
// - Read gives count, write loads preload.
// - Timer and pulse modes use system clock.
// - Prescaler only in some variants.
// - Event mode counts selected pin edges.
// - Each tick adds exactly one.
// - Passing all-ones overflows, raises interrupt.
// - Overflow reloads preload, keeps counting.
// - Preload undefined until software writes it.
// - Stopped: preload write also loads counter.
// - Running: preload enters at next overflow.
// - Low byte write goes to buffer.
// - High write also moves buffer to low.
// - Mode field sits in bits 7 and 6.
// - Bit 4 is the run bit.
// - Bits 0 to 2 select prescale.
// - Prescale ignored with external clock.
// - Bit 3 selects active edge.
// - Mode 10 is interval timer.
// - Mode 01 counts rising or falling edges.
// - Mode 11 measures pulse, clears run.
// - 16-bit variant counts clock divided four.
`timescale 1ns/1ps
module tec_counter
  import tec_pkg::*;
#(
  parameter int WIDTH = TEC_WIDTH_DEF,
  parameter bit HAS_PRESCALER = (WIDTH == 8)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic external_count_pin,
  output logic overflow_irq_q
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] preload_q;
  logic [7:0] low_buf_q;
  logic [7:0] ctrl_q;
  logic [7:0] psc_q;
  logic [1:0] div4_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_prev_q;
  logic pulse_act_q;

  // ------------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------------
  tec_mode_e mode;
  wire logic run_bit = ctrl_q[TEC_RUN_BIT];
  wire logic edge_pol = ctrl_q[TEC_EDGE_BIT];
  wire logic [2:0] psc_sel = ctrl_q[TEC_PSC_HI:TEC_PSC_LO];
  assign mode = tec_mode_e'(ctrl_q[TEC_MODE_HI:TEC_MODE_LO]);
  wire logic wr_low = reg_wr && reg_sel == TEC_SEL_LOW;
  wire logic wr_high = reg_wr && reg_sel == TEC_SEL_HIGH && WIDTH > 8;
  wire logic wr_ctrl = reg_wr && reg_sel == TEC_SEL_CTRL;
  wire logic rd_high = reg_rd && reg_sel == TEC_SEL_HIGH && WIDTH > 8;

  // Only the second synchroniser stage feeds edge detection.
  wire logic rise = pin_s2_q && !pin_prev_q;
  wire logic fall = !pin_s2_q && pin_prev_q;
  wire logic act_edge = edge_pol ? fall : rise;
  wire logic end_edge = edge_pol ? rise : fall;
  // Pulse mode starts on the edge that leaves the idle level, so the
  // polarity bit means the opposite of what it means for event counting.
  wire logic pulse_start = edge_pol ? rise : fall;
  wire logic pulse_stop = edge_pol ? fall : rise;

  // Internal tick: prescaler on 8-bit, divide by four on 16-bit.
  wire logic psc_tick = (psc_sel == 3'h0) ? 1'b1 : (psc_q == 8'h00);
  wire logic int_tick = (WIDTH > 8) ? (div4_q == TEC_DIV16_CYCLES) :
                        (HAS_PRESCALER ? psc_tick : 1'b1);
  wire logic tick = run_bit && ((mode == TEC_TIMER && int_tick) ||
                                (mode == TEC_EVENT && act_edge) ||
                                (mode == TEC_PULSE && pulse_act_q && int_tick));
  wire logic pulse_end = mode == TEC_PULSE && run_bit && pulse_act_q && pulse_stop;
  wire logic at_full = &count_q;
  wire logic ovf = tick && at_full;

  // Preload image after a write this cycle.
  logic [WIDTH-1:0] preload_d;
  if (WIDTH > 8) begin : g_wide
    assign preload_d = wr_high ? WIDTH'({reg_wdata, low_buf_q}) : preload_q;
  end else begin : g_narrow
    assign preload_d = wr_low ? WIDTH'(reg_wdata) : preload_q;
  end
  wire logic pre_wr = (WIDTH > 8) ? wr_high : wr_low;

  logic [WIDTH-1:0] count_d;
  assign count_d = ovf ? preload_d :
                   (pre_wr && !run_bit) ? preload_d :
                   tick ? count_q + WIDTH'(1) : count_q;

  logic [7:0] ctrl_d;
  assign ctrl_d = wr_ctrl ? (reg_wdata & TEC_CTRL_MASK) :
                  pulse_end ? (ctrl_q & ~(8'h01 << TEC_RUN_BIT)) : ctrl_q;

  wire logic [7:0] rd_mux = (reg_sel == TEC_SEL_CTRL) ? ctrl_q :
                            (reg_sel == TEC_SEL_HIGH) ? 8'(count_q >> 8) :
                            (WIDTH > 8) ? low_buf_q : count_q[7:0];

  // ------------------------------------------------------------------
  // Sequential logic
  // ------------------------------------------------------------------
  // Preload carries no reset: it is undefined until written.
  always_ff @(posedge clk) begin
    preload_q <= preload_d;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= TEC_CTRL_RESET;
      count_q <= '0;
      low_buf_q <= 8'h00;
      psc_q <= 8'h00;
      div4_q <= 2'h0;
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
      pulse_act_q <= 1'b0;
      overflow_irq_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      if (wr_low) begin
        low_buf_q <= reg_wdata;
      end else if (rd_high) begin
        low_buf_q <= count_q[7:0];
      end
      psc_q <= (psc_tick || !run_bit) ? 8'((9'h001 << psc_sel) - 9'h001) : psc_q - 8'h01;
      div4_q <= div4_q + 2'h1;
      pin_s1_q <= external_count_pin;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
      if (!run_bit || mode != TEC_PULSE || pulse_end) begin
        pulse_act_q <= 1'b0;
      end else if (pulse_start) begin
        pulse_act_q <= 1'b1;
      end
      overflow_irq_q <= ovf;
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_pulse_done;
    pulse_end ##1 !run_bit;
  endsequence

  irq_one_cycle_a: assert property (@(posedge clk) disable iff (!rstn)
    overflow_irq_q |=> !overflow_irq_q) else $error("overflow pulse too long");
  irq_follows_ovf_a: assert property (@(posedge clk) disable iff (!rstn)
    ovf |=> overflow_irq_q) else $error("overflow not signalled");
  reload_value_a: assert property (@(posedge clk) disable iff (!rstn)
    ovf && !reg_wr |=> count_q == $past(preload_q)) else $error("no reload");
  step_one_a: assert property (@(posedge clk) disable iff (!rstn)
    tick && !at_full && !reg_wr |=> count_q == $past(count_q) + WIDTH'(1))
    else $error("count step wrong");
  off_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    mode == TEC_OFF && !reg_wr |=> $stable(count_q)) else $error("off mode counted");
  pulse_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    s_pulse_done |-> !pulse_act_q) else $error("pulse end left running");
  stopped_load_a: assert property (@(posedge clk) disable iff (!rstn)
    pre_wr && !run_bit |=> count_q == preload_q) else $error("stopped load missed");
  low_buffered_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_low && WIDTH > 8 && !tick |=> $stable(count_q)) else $error("low write hit counter");

  // ------------------------------------------------------------------
  // Tick source checks
  // ------------------------------------------------------------------
  sequence s_quiet3;
    !int_tick [*3];
  endsequence

  div4_period_a: assert property (@(posedge clk) disable iff (!rstn)
    int_tick && WIDTH > 8 |=> s_quiet3 ##1 int_tick)
    else $error("internal tick period wrong");

  timer_tick_a: assert property (@(posedge clk) disable iff (!rstn)
    mode == TEC_TIMER && run_bit |-> tick == int_tick)
    else $error("timer tick source wrong");

  event_tick_a: assert property (@(posedge clk) disable iff (!rstn)
    mode == TEC_EVENT && run_bit |-> tick == act_edge)
    else $error("event tick source wrong");

  stopped_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !run_bit && !reg_wr |=> $stable(count_q))
    else $error("stopped counter moved");

  // ------------------------------------------------------------------
  // Pulse width checks
  // ------------------------------------------------------------------
  pulse_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    mode == TEC_PULSE && !pulse_act_q |-> !tick)
    else $error("pulse counted before start");

  pulse_start_a: assert property (@(posedge clk) disable iff (!rstn)
    mode == TEC_PULSE && run_bit && !pulse_act_q && pulse_start && !wr_ctrl |=> pulse_act_q)
    else $error("pulse start missed");

  run_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    pulse_end && !wr_ctrl |=> !run_bit)
    else $error("run bit not cleared");

  // ------------------------------------------------------------------
  // Register checks
  // ------------------------------------------------------------------
  run_write_a: assert property (@(posedge clk) disable iff (!rstn)
    pre_wr && run_bit && !tick |=> $stable(count_q))
    else $error("running write hit counter");

  high_write_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_high |=> preload_q == WIDTH'({$past(reg_wdata), $past(low_buf_q)}))
    else $error("high write not committed");

  narrow_write_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_low && WIDTH == 8 |=> preload_q == WIDTH'($past(reg_wdata)))
    else $error("preload write lost");

  low_buf_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_low |=> low_buf_q == $past(reg_wdata))
    else $error("low buffer not written");

  high_latch_a: assert property (@(posedge clk) disable iff (!rstn)
    rd_high && !wr_low |=> low_buf_q == $past(count_q[7:0]))
    else $error("low byte not latched");

  rd_data_a: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd |=> reg_rdata_q == $past(rd_mux))
    else $error("read data wrong");

  rd_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed");

  ctrl_write_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl |=> ctrl_q == ($past(reg_wdata) & TEC_CTRL_MASK))
    else $error("control write lost");

  // Unused control bit 5 must never read back as set.
  ctrl_spare_a: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl_q & ~TEC_CTRL_MASK) == 8'h00)
    else $error("spare control bit set");

  // ------------------------------------------------------------------
  // Interrupt and pin checks
  // ------------------------------------------------------------------
  irq_only_ovf_a: assert property (@(posedge clk) disable iff (!rstn)
    !ovf |=> !overflow_irq_q)
    else $error("spurious overflow");

  off_no_irq_a: assert property (@(posedge clk) disable iff (!rstn)
    mode == TEC_OFF |=> !overflow_irq_q)
    else $error("off mode overflowed");

  sync_chain_a: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> pin_s2_q == $past(pin_s1_q) && pin_prev_q == $past(pin_s2_q))
    else $error("pin synchroniser broken");
endmodule

/* File: testbench/tec_pin_src.sv */
// Purpose: Stands in for the logic source that drives the external count pin.
// Assumes: One system clock; the source is a plain push-pull level.
// Notes: The pin toggles every eight clocks while enabled, otherwise it holds its level.
`timescale 1ns/1ps
module tec_pin_src (
  input wire logic clk,
  input wire logic en,
  output logic pin
);
  logic [2:0] div_q = 3'h0;
  initial pin = 1'b0;
  always @(posedge clk) begin
    if (en) begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h7) begin
        pin <= ~pin;
      end
    end
  end
endmodule

/* File: testbench/timer_event_counter_bench.sv */
// Purpose: Self-checking bench for the 16-bit timer/event counter.
// Assumes: Each register write takes two clocks and each read three, so strobes never retoggle in one step.
// Notes: Overflow timing is checked in windows, since the divide-by-four phase and the register accesses shift it.
`timescale 1ns/1ps
module timer_event_counter_bench;
  import tec_pkg::*;
  logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, pin_en = 0;
  logic [1:0] sel = 2'h0;
  logic [7:0] wd = 8'h00;
  wire [7:0] rd;
  wire pin, ov;
  int bad_count = 0, tests_run = 0, n = 0, edges = 0, falls = 0, i;
  time t0;
  logic [7:0] rows [4][2] = '{'{8'h00, 8'h00}, '{8'h2F, 8'h0F}, '{8'h48, 8'h48}, '{8'h87, 8'h87}};
  always #2 clk = ~clk;
  always @(posedge pin) edges++;
  always @(negedge pin) falls++;
  tec_counter DUT (.clk(clk), .rstn(rstn), .reg_sel(sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(wd), .reg_rdata_q(rd), .external_count_pin(pin), .overflow_irq_q(ov));
  tec_pin_src PIN (.clk(clk), .en(pin_en), .pin(pin));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk) #1 begin sel = s; wd = d; reg_wr = 1; end
    @(posedge clk) #1 reg_wr = 0;
  endtask
  task automatic rdchk(input string name, input logic [1:0] s, input logic [7:0] exp);
    @(posedge clk) #1 begin sel = s; reg_rd = 1; end
    @(posedge clk) #1 reg_rd = 0;
    @(posedge clk) #1 check(name, rd, exp);
  endtask
  task automatic pre(input logic [15:0] v);
    wr(TEC_SEL_LOW, v[7:0]);
    wr(TEC_SEL_HIGH, v[15:8]);
  endtask
  task automatic wait_irq();
    n = 0;
    @(posedge clk) #1;
    while (ov !== 1'b1 && n < 300) begin
      @(posedge clk) #1 n++;
    end
    if (n >= 300) begin
      bad_count++;
      end_sim();
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1;
    rdchk("ctrl_reset", TEC_SEL_CTRL, TEC_CTRL_RESET);
    // ---------------------------------------------------------------
    // Control field layout, table driven.
    // ---------------------------------------------------------------
    for (i = 0; i < 4; i++) begin
      wr(TEC_SEL_CTRL, rows[i][0]);
      rdchk("ctrl_rows", TEC_SEL_CTRL, rows[i][1]);
    end
    wr(TEC_SEL_CTRL, 8'h00);
    pre(16'h1234);
    wr(TEC_SEL_LOW, 8'h55);
    rdchk("stop_hi", TEC_SEL_HIGH, 8'h12);
    rdchk("stop_lo", TEC_SEL_LOW, 8'h34);
    // ---------------------------------------------------------------
    // Timer mode with a preload change while running.
    // ---------------------------------------------------------------
    pre(16'hFFF0);
    wr(TEC_SEL_CTRL, 8'h90);
    t0 = $time;
    pre(16'hFFFE);
    wait_irq();
    check("first_ov", 8'((($time - t0) / 4) inside {[60:72]}), 8'h01);
    wait_irq();
    check("reload_ov", 8'(n inside {[6:9]}), 8'h01);
    // ---------------------------------------------------------------
    // Off mode ignores the pin; event mode counts rising edges, then falling edges.
    // ---------------------------------------------------------------
    wr(TEC_SEL_CTRL, 8'h00);
    pre(16'hFFFD);
    wr(TEC_SEL_CTRL, 8'h10);
    pin_en = 1;
    repeat (40) @(posedge clk);
    #1 pin_en = 0;
    rdchk("off_hi", TEC_SEL_HIGH, 8'hFF);
    rdchk("off_lo", TEC_SEL_LOW, 8'hFD);
    edges = 0;
    wr(TEC_SEL_CTRL, 8'h50);
    pin_en = 1;
    wait_irq();
    check("event_edges", 8'(edges), 8'h03);
    pin_en = 0;
    wr(TEC_SEL_CTRL, 8'h00);
    pre(16'hFFFE);
    falls = 0;
    wr(TEC_SEL_CTRL, 8'h58);
    pin_en = 1;
    wait_irq();
    check("fall_edges", 8'(falls), 8'h02);
    // ---------------------------------------------------------------
    // Pulse width mode clears the run bit itself.
    // ---------------------------------------------------------------
    pin_en = 0;
    wr(TEC_SEL_CTRL, 8'h00);
    pre(16'h0000);
    wr(TEC_SEL_CTRL, 8'hD0);
    pin_en = 1;
    repeat (60) @(posedge clk);
    #1 pin_en = 0;
    rdchk("pulse_run", TEC_SEL_CTRL, 8'hC0);
    rdchk("pulse_hi", TEC_SEL_HIGH, 8'h00);
    end_sim();
  end
endmodule
